// ==== design/ulf_rx_line_status.sv ====
// Purpose: serial receiver with line status flags, 16-entry fifo and AXI4-Lite registers
// Assumes: 16 samples per bit, sample rate set by the divisor register
// Notes: receiver, fifo and flags share one clock
`timescale 1ns/100ps
`include "ulf_cfg.svh"
`default_nettype none
module ulf_rx_line_status
	import ulf_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic SRST_I,
	// Serial line
	input wire logic RXD_I,
	// AXI4-Lite write
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	// AXI4-Lite read
	input wire logic [7:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	// Interrupt
	output logic IRQ_O
);
	function automatic logic ulf_hit(input logic [7:0] addr, input logic [5:0] idx);
		ulf_hit = (addr[7:2] == idx);
	endfunction
	function automatic logic [7:0] ulf_align(input logic [7:0] sh, input logic [1:0] wls);
		ulf_align = sh >> (2'd3 - wls);
	endfunction

	logic rx_s1_q, rx_s2_q;
	logic [7:0] lcr_q, fcr_q;
	logic [15:0] div_q, div_cnt_q;
	logic [1:0] ist_q, imsk_q;
	logic tick;
	ulf_rx_state_t state_q;
	logic [3:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q, brk_cnt_q;
	logic par_q, brk_sent_q;
	logic push_q;
	ulf_word_t push_word_q;
	ulf_word_t mem [0:15];
	ulf_word_t hold_q;
	logic hold_full_q;
	logic [3:0] wr_ptr_q, rd_ptr_q;
	logic [4:0] count_q;
	logic head_fresh_q;
	logic brk_q, frm_q, prt_q, ovr_q;
	logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q, rdata_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;

	// Two flops before anything reads the pin
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= RXD_I;
			rx_s2_q <= rx_s1_q;
		end
	end

	// Sample tick, divisor of zero acts as one
	assign tick = (div_cnt_q + 16'h0001 >= div_q);
	always_ff @(posedge CLK_I) begin
		if (SRST_I || tick) begin
			div_cnt_q <= 16'h0000;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// Frame geometry
	logic fifo_en, pen, eps, stop2;
	logic [1:0] wls;
	logic [3:0] nbits, char_bits;
	logic [7:0] char_ticks, rx_data;
	logic par_err, zero_word, brk_hit, go_resync;
	assign fifo_en = fcr_q[`ULF_FCR_EN];
	assign wls = lcr_q[1:0];
	assign pen = lcr_q[`ULF_LCR_PEN];
	assign eps = lcr_q[`ULF_LCR_EPS];
	assign stop2 = lcr_q[`ULF_LCR_STOP2];
	assign nbits = {2'b00, wls} + 4'h5;
	assign char_bits = nbits + 4'h2 + {3'b000, pen} + {3'b000, stop2};
	assign char_ticks = {char_bits, 4'h0};
	assign rx_data = ulf_align(sh_q, wls);
	assign par_err = pen & (eps ? (^rx_data ^ par_q) : ~(^rx_data ^ par_q));
	assign zero_word = (rx_data == 8'h00) && !(pen && par_q);
	assign brk_hit = tick && !rx_s2_q && (brk_cnt_q == char_ticks);
	// Only the first stop bit is looked at
	assign go_resync = (state_q == ULF_STOP) && tick && (cnt_q == `ULF_OVS_LAST)
		&& !rx_s2_q && !zero_word;

	// Low-time counter saturates so a long break is reported once
	always_ff @(posedge CLK_I) begin
		if (SRST_I || rx_s2_q) begin
			brk_cnt_q <= 8'h00;
		end else if (tick && brk_cnt_q != 8'hFF) begin
			brk_cnt_q <= brk_cnt_q + 8'h01;
		end
	end

	// Receiver
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			state_q <= ULF_IDLE;
			cnt_q <= 4'h0;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			par_q <= 1'b0;
			brk_sent_q <= 1'b0;
			push_q <= 1'b0;
			push_word_q <= '0;
		end else begin
			push_q <= 1'b0;
			if (tick) begin
				cnt_q <= cnt_q + 4'h1;
			end
			case (state_q)
				ULF_IDLE: begin
					if (tick && !rx_s2_q) begin
						state_q <= ULF_START;
						cnt_q <= 4'h0;
					end
				end
				ULF_START: begin
					if (tick && rx_s2_q && (cnt_q == `ULF_START_S1 || cnt_q == `ULF_START_S2)) begin
						state_q <= ULF_IDLE;
					end else if (tick && cnt_q == `ULF_START_S2) begin
						state_q <= ULF_DATA;
						cnt_q <= 4'h0;
						bit_q <= 3'h0;
					end
				end
				ULF_DATA: begin
					if (tick && cnt_q == `ULF_OVS_LAST) begin
						sh_q <= {rx_s2_q, sh_q[7:1]};
						bit_q <= bit_q + 3'h1;
						if ({1'b0, bit_q} == nbits - 4'h1) begin
							state_q <= pen ? ULF_PAR : ULF_STOP;
						end
					end
				end
				ULF_PAR: begin
					if (tick && cnt_q == `ULF_OVS_LAST) begin
						par_q <= rx_s2_q;
						state_q <= ULF_STOP;
					end
				end
				ULF_STOP: begin
					if (tick && cnt_q == `ULF_OVS_LAST) begin
						if (rx_s2_q) begin
							push_q <= 1'b1;
							push_word_q <= {1'b0, 1'b0, par_err, rx_data};
							state_q <= ULF_IDLE;
						end else if (zero_word) begin
							// Could be a break; hold the character until the line decides
							state_q <= ULF_BRKW;
						end else begin
							push_q <= 1'b1;
							push_word_q <= {1'b0, 1'b1, par_err, rx_data};
							state_q <= ULF_START;
							cnt_q <= `ULF_START_S1;
						end
					end
					if (!pen) begin
						par_q <= 1'b0;
					end
				end
				ULF_BRKW: begin
					if (brk_sent_q) begin
						if (rx_s2_q) begin
							brk_sent_q <= 1'b0;
							state_q <= ULF_IDLE;
						end
					end else if (rx_s2_q) begin
						push_q <= 1'b1;
						push_word_q <= {1'b0, 1'b1, par_err, 8'h00};
						state_q <= ULF_IDLE;
					end else if (brk_hit) begin
						push_q <= 1'b1;
						push_word_q <= {1'b1, 1'b1, 1'b0, 8'h00};
						brk_sent_q <= 1'b1;
					end
				end
				default: begin
					state_q <= ULF_IDLE;
				end
			endcase
		end
	end

	// Bus strobes
	logic ar_hs, do_write, lsr_rd, pop, flush, ovf_evt, push_ok, stat_evt, rx_avail;
	ulf_word_t head_word, stat_word;
	assign ar_hs = AXI_ARVALID_I && !rvalid_q;
	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign lsr_rd = ar_hs && ulf_hit(AXI_ARADDR_I, `ULF_IDX_LSR);
	assign rx_avail = fifo_en ? (count_q != 5'h00) : hold_full_q;
	assign pop = ar_hs && ulf_hit(AXI_ARADDR_I, `ULF_IDX_RXH) && rx_avail;
	assign flush = do_write && ulf_hit(awaddr_q, `ULF_IDX_FCR) && wstrb_q[0]
		&& (wdata_q[`ULF_FCR_FLUSH] || wdata_q[`ULF_FCR_EN] != fifo_en);
	assign ovf_evt = push_q && (fifo_en ? (count_q == `ULF_FIFO_DEPTH) : (hold_full_q && !pop));
	assign push_ok = push_q && fifo_en && (count_q != `ULF_FIFO_DEPTH) && !flush;
	assign head_word = mem[rd_ptr_q];
	// Status follows the head in fifo mode, the newest character otherwise
	assign stat_evt = fifo_en ? head_fresh_q : push_q;
	assign stat_word = fifo_en ? head_word : push_word_q;

	// Storage has no reset; pointers and count define what is valid
	always_ff @(posedge CLK_I) begin
		if (push_ok) begin
			mem[wr_ptr_q] <= push_word_q;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I || flush) begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			count_q <= 5'h00;
			head_fresh_q <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_q + {3'b000, push_ok};
			rd_ptr_q <= rd_ptr_q + {3'b000, pop && fifo_en};
			count_q <= count_q + {4'h0, push_ok} - {4'h0, pop && fifo_en};
			head_fresh_q <= (pop && fifo_en && count_q > 5'h01)
				|| (push_ok && (count_q == 5'h00 || (pop && count_q == 5'h01)));
		end
	end

	// Holding register for non-fifo mode; a new character overwrites
	always_ff @(posedge CLK_I) begin
		if (SRST_I || flush) begin
			hold_q <= '0;
			hold_full_q <= 1'b0;
		end else if (push_q && !fifo_en) begin
			hold_q <= push_word_q;
			hold_full_q <= 1'b1;
		end else if (pop && !fifo_en) begin
			hold_full_q <= 1'b0;
		end
	end

	// Error flags: a new event beats a clearing read
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			brk_q <= 1'b0;
			frm_q <= 1'b0;
			prt_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			brk_q <= (brk_q && !lsr_rd) || (stat_evt && stat_word[`ULF_W_BI]);
			frm_q <= (frm_q && !lsr_rd) || (stat_evt && stat_word[`ULF_W_FE]);
			prt_q <= (prt_q && !lsr_rd) || (stat_evt && stat_word[`ULF_W_PE]);
			ovr_q <= (ovr_q && !lsr_rd) || ovf_evt;
		end
	end

	// Interrupt status, write one to clear, set wins
	logic [1:0] ist_set, ist_clr;
	assign ist_set[`ULF_IRQ_DATA] = push_q && !ovf_evt;
	assign ist_set[`ULF_IRQ_LINE] = ovf_evt
		|| (stat_evt && |stat_word[`ULF_W_BI:`ULF_W_PE]);
	assign ist_clr = (do_write && ulf_hit(awaddr_q, `ULF_IDX_IST) && wstrb_q[0]) ? wdata_q[1:0] : 2'b00;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ist_q <= 2'b00;
		end else begin
			ist_q <= (ist_q & ~ist_clr) | ist_set;
		end
	end
	assign IRQ_O = |(ist_q & imsk_q);

	// Control registers
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			lcr_q <= `ULF_LCR_RST;
			fcr_q <= `ULF_FCR_RST;
			div_q <= `ULF_DIV_RST;
			imsk_q <= `ULF_IMSK_RST;
		end else if (do_write) begin
			if (ulf_hit(awaddr_q, `ULF_IDX_LCR) && wstrb_q[0]) begin
				lcr_q <= {3'b000, wdata_q[4:0]};
			end
			// Flush bit is a strobe and never stored
			if (ulf_hit(awaddr_q, `ULF_IDX_FCR) && wstrb_q[0]) begin
				fcr_q <= {7'h00, wdata_q[`ULF_FCR_EN]};
			end
			if (ulf_hit(awaddr_q, `ULF_IDX_DIV) && wstrb_q[0]) begin
				div_q[7:0] <= wdata_q[7:0];
			end
			if (ulf_hit(awaddr_q, `ULF_IDX_DIV) && wstrb_q[1]) begin
				div_q[15:8] <= wdata_q[15:8];
			end
			if (ulf_hit(awaddr_q, `ULF_IDX_IMSK) && wstrb_q[0]) begin
				imsk_q <= wdata_q[1:0];
			end
		end
	end

	// AXI4-Lite write path, one write at a time
	logic wr_mapped;
	assign wr_mapped = ulf_hit(awaddr_q, `ULF_IDX_RXH) || ulf_hit(awaddr_q, `ULF_IDX_FCR)
		|| ulf_hit(awaddr_q, `ULF_IDX_LCR) || ulf_hit(awaddr_q, `ULF_IDX_LSR)
		|| ulf_hit(awaddr_q, `ULF_IDX_DIV) || ulf_hit(awaddr_q, `ULF_IDX_IST)
		|| ulf_hit(awaddr_q, `ULF_IDX_IMSK);
	assign AXI_AWREADY_O = !aw_full_q && !bvalid_q;
	assign AXI_WREADY_O = !w_full_q && !bvalid_q;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `ULF_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (AXI_AWVALID_I && AXI_AWREADY_O) begin
				aw_full_q <= 1'b1;
				awaddr_q <= AXI_AWADDR_I;
			end
			if (AXI_WVALID_I && AXI_WREADY_O) begin
				w_full_q <= 1'b1;
				wdata_q <= AXI_WDATA_I;
				wstrb_q <= AXI_WSTRB_I;
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? `ULF_RESP_OKAY : `ULF_RESP_SLVERR;
			end else if (bvalid_q && AXI_BREADY_I) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign AXI_BVALID_O = bvalid_q;
	assign AXI_BRESP_O = bresp_q;

	// AXI4-Lite read path; reads of the holding and line state registers have side effects
	logic [7:0] rd_mux;
	logic rd_mapped;
	always_comb begin
		rd_mux = 8'h00;
		rd_mapped = 1'b1;
		if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_RXH)) begin
			rd_mux = fifo_en ? head_word[7:0] : hold_q[7:0];
		end else if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_FCR)) begin
			rd_mux = fcr_q;
		end else if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_LCR)) begin
			rd_mux = lcr_q;
		end else if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_LSR)) begin
			rd_mux = {3'b000, brk_q, frm_q, prt_q, ovr_q, rx_avail};
		end else if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_DIV)) begin
			rd_mux = div_q[7:0];
		end else if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_IST)) begin
			rd_mux = {6'h00, ist_q};
		end else if (ulf_hit(AXI_ARADDR_I, `ULF_IDX_IMSK)) begin
			rd_mux = {6'h00, imsk_q};
		end else begin
			rd_mapped = 1'b0;
		end
	end
	assign AXI_ARREADY_O = !rvalid_q;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rvalid_q <= 1'b0;
			rdata_q <= 8'h00;
			rresp_q <= `ULF_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_mapped ? `ULF_RESP_OKAY : `ULF_RESP_SLVERR;
		end else if (AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
		end
	end
	assign AXI_RVALID_O = rvalid_q;
	assign AXI_RRESP_O = rresp_q;
	// Divisor is the only register wider than one byte
	logic rd_hi_q;
	logic [7:0] div_hi_q;
	assign AXI_RDATA_O = (rd_hi_q) ? {16'h0000, div_hi_q, rdata_q} : {24'h00_0000, rdata_q};
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rd_hi_q <= 1'b0;
			div_hi_q <= 8'h00;
		end else if (ar_hs) begin
			rd_hi_q <= ulf_hit(AXI_ARADDR_I, `ULF_IDX_DIV);
			div_hi_q <= div_q[15:8];
		end
	end

	// Checks
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	property p_brk_push;
		brk_hit && state_q == ULF_BRKW && !brk_sent_q |=> push_q && push_word_q == 11'h600;
	endproperty
	a_brk_push: assert property (p_brk_push) else $error("break did not push one zero word");
	property p_brk_once;
		brk_sent_q && !rx_s2_q |=> !push_q;
	endproperty
	a_brk_once: assert property (p_brk_once) else $error("second push during one break");
	property p_resync;
		go_resync |=> state_q == ULF_START && cnt_q == 4'h7 && push_q && push_word_q[9];
	endproperty
	a_resync: assert property (p_resync) else $error("no resync after bad stop bit");
	property p_lsr_clear;
		lsr_rd && !stat_evt && !ovf_evt |=> !brk_q && !frm_q && !prt_q && !ovr_q;
	endproperty
	a_lsr_clear: assert property (p_lsr_clear) else $error("line state read left a flag set");
	property p_head_flags;
		fifo_en && head_fresh_q
			|=> (frm_q || !$past(head_word[9])) && (prt_q || !$past(head_word[8]));
	endproperty
	a_head_flags: assert property (p_head_flags) else $error("head tags not shown");
	property p_fifo_ovr;
		fifo_en && push_q && count_q == 5'h10 && !flush |=> ovr_q && count_q == $past(count_q) - {4'h0, $past(pop)};
	endproperty
	a_fifo_ovr: assert property (p_fifo_ovr) else $error("full fifo stored a byte");
	property p_hold_ovr;
		!fifo_en && push_q && hold_full_q && !pop && !flush |=> ovr_q && hold_full_q;
	endproperty
	a_hold_ovr: assert property (p_hold_ovr) else $error("overwrite without overrun");
	property p_avail_set;
		push_q && !ovf_evt && !flush && !pop |=> rx_avail;
	endproperty
	a_avail_set: assert property (p_avail_set) else $error("data available missing");
	property p_hold_read;
		!fifo_en && pop && !push_q |=> !rx_avail;
	endproperty
	a_hold_read: assert property (p_hold_read) else $error("holding read kept data available");
	property p_flush;
		flush |=> !rx_avail ##1 (!rx_avail || $past(push_q));
	endproperty
	a_flush: assert property (p_flush) else $error("flush left data available");
	property p_line_irq;
		fifo_en && head_fresh_q && head_word[10] |=> ist_q[1];
	endproperty
	a_line_irq: assert property (p_line_irq) else $error("head error gave no interrupt");
	c_break: cover property (push_q && push_word_q[10]);
	c_fifo_full: cover property (fifo_en && count_q == 5'h10 && push_q);
	c_resync: cover property (go_resync ##[1:200] push_q && !push_word_q[9]);
endmodule
`default_nettype wire

// ==== design/ulf_cfg.svh ====
// Purpose: offsets, field positions, reset values and counts for the receive line status block
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: definitions only
`ifndef ULF_CFG_SVH
`define ULF_CFG_SVH
// Register indices, byte address = index * 4
`define ULF_IDX_RXH 6'h00
`define ULF_IDX_FCR 6'h02
`define ULF_IDX_LCR 6'h03
`define ULF_IDX_LSR 6'h05
`define ULF_IDX_DIV 6'h08
`define ULF_IDX_IST 6'h09
`define ULF_IDX_IMSK 6'h0A
// Line state bits
`define ULF_LSR_AVAIL 0
`define ULF_LSR_OVR 1
`define ULF_LSR_PAR 2
`define ULF_LSR_FRM 3
`define ULF_LSR_BRK 4
// Fifo control bits
`define ULF_FCR_EN 0
`define ULF_FCR_FLUSH 1
// Line control bits
`define ULF_LCR_STOP2 2
`define ULF_LCR_PEN 3
`define ULF_LCR_EPS 4
// Interrupt status bits
`define ULF_IRQ_DATA 0
`define ULF_IRQ_LINE 1
// Stored word tag bits above the data byte
`define ULF_W_PE 8
`define ULF_W_FE 9
`define ULF_W_BI 10
// Reset values
`define ULF_LCR_RST 8'h00
`define ULF_FCR_RST 8'h00
`define ULF_DIV_RST 16'h0001
`define ULF_IMSK_RST 2'h0
// Counts
`define ULF_FIFO_DEPTH 5'h10
`define ULF_OVS_LAST 4'hF
`define ULF_START_S1 4'h7
`define ULF_START_S2 4'h8
`define ULF_RESP_OKAY 2'h0
`define ULF_RESP_SLVERR 2'h2
`endif

// ==== design/ulf_pkg.sv ====
// Purpose: types of the receive line status block
// Assumes: nothing
// Notes: one-hot receiver states
package ulf_pkg;
	typedef enum logic [5:0] {
		ULF_IDLE = 6'h01,
		ULF_START = 6'h02,
		ULF_DATA = 6'h04,
		ULF_PAR = 6'h08,
		ULF_STOP = 6'h10,
		ULF_BRKW = 6'h20
	} ulf_rx_state_t;
	typedef logic [10:0] ulf_word_t;
endpackage

// ==== sim/ulf_tx_model.sv ====
// Purpose: remote serial transmitter driving the receive line
// Assumes: line idles high, one bit lasts BIT_CLKS clocks
// Notes: caller picks the parity bit value, so bad parity can be sent
`timescale 1ns/100ps
`default_nettype none
module ulf_tx_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk_i,
	output var logic rxd_o
);
	initial rxd_o = 1'b1;
	task automatic put_bit(input logic b);
		rxd_o <= b;
		repeat (BIT_CLKS) @(posedge clk_i);
	endtask
	// Stop code 2 leaves the stop slot to the next start bit
	task automatic frame(input logic [7:0] d, input int nb, input logic pen, input logic pb,
		input int stop, input int idle);
		put_bit(1'b0);
		for (int i = 0; i < nb; i++) put_bit(d[i]);
		if (pen) put_bit(pb);
		if (stop != 2) put_bit(stop[0]);
		repeat (idle) put_bit(1'b1);
	endtask
	// Line held low, then back to idle for two bits
	task automatic hold_low(input int bits);
		repeat (bits) put_bit(1'b0);
		repeat (2) put_bit(1'b1);
	endtask
endmodule
`default_nettype wire

// ==== sim/test_ulf_rx_line_status.sv ====
// Purpose: self-checking bench for the receive line status block
// Assumes: divisor stays 1 while serial data flows, so a bit is 16 clocks
// Notes: registers over AXI4-Lite, serial data from ulf_tx_model
`timescale 1ns/100ps
`include "ulf_cfg.svh"
`default_nettype none
module test_ulf_rx_line_status;
	import ulf_pkg::*;
	localparam logic [7:0] A_RXH = {`ULF_IDX_RXH, 2'b00};
	localparam logic [7:0] A_FCR = {`ULF_IDX_FCR, 2'b00};
	localparam logic [7:0] A_LCR = {`ULF_IDX_LCR, 2'b00};
	localparam logic [7:0] A_LSR = {`ULF_IDX_LSR, 2'b00};
	localparam logic [7:0] A_DIV = {`ULF_IDX_DIV, 2'b00};
	localparam logic [7:0] A_IST = {`ULF_IDX_IST, 2'b00};
	localparam logic [7:0] A_MSK = {`ULF_IDX_IMSK, 2'b00};
	typedef struct packed {logic [7:0] lcr; logic [7:0] d; logic pbad; logic [7:0] line_state_reg;} ulf_row_t;
	// Every word length; even parity sent bad, odd parity sent good
	ulf_row_t rows [4] = '{'{8'h00, 8'h15, 1'b0, 8'h01}, '{8'h19, 8'h2A, 1'b1, 8'h05},
		'{8'h0A, 8'h4B, 1'b0, 8'h01}, '{8'h1B, 8'h3C, 1'b1, 8'h05}};
	logic clk, srst, rxd, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0] awaddr, araddr, lcr_v;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, got;
	logic [1:0] bresp, rresp, resp;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	ulf_rx_line_status uut (.CLK_I(clk), .SRST_I(srst), .RXD_I(rxd), .AXI_AWADDR_I(awaddr),
		.AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata),
		.AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
		.AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
		.AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
		.AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
		.AXI_RREADY_I(rready), .IRQ_O(irq));
	ulf_tx_model #(.BIT_CLKS(16)) tx (.clk_i(clk), .rxd_o(rxd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Whole run needs under 10000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Extra edge at the end so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
		rd(a);
		chk(what, e, got);
	endtask
	task automatic setlcr(input logic [7:0] v);
		lcr_v = v;
		wr(A_LCR, {24'h0, v});
	endtask
	task automatic send(input logic [7:0] d, input logic pbad, input int stop, input int idle);
		int nb;
		logic [7:0] m;
		nb = 5 + lcr_v[1:0];
		m = d & ((8'h01 << nb) - 8'h01);
		tx.frame(m, nb, lcr_v[3], (^m) ^ ~lcr_v[4] ^ pbad, stop, idle);
	endtask
	initial begin
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		lcr_v = 8'h00;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			setlcr(rows[i].lcr);
			send(rows[i].d, rows[i].pbad, 1, 1);
			rc(A_LSR, {24'h0, rows[i].line_state_reg}, "row line state");
			rc(A_RXH, {24'h0, rows[i].d}, "row data");
			rc(A_LSR, 32'h0, "row cleared");
			$display("row %0d done", i);
		end
		setlcr(8'h03);
		send(8'h11, 0, 1, 1);
		send(8'h22, 0, 1, 1);
		rc(A_LSR, 32'h03, "overrun");
		rc(A_RXH, 32'h22, "overwritten data");
		rc(A_LSR, 32'h00, "overrun cleared");
		rc(A_IST, 32'h03, "non-fifo irq status");
		wr(A_IST, 32'h03);
		$display("overrun test done");
		wr(A_FCR, 32'h01);
		setlcr(8'h1B);
		send(8'h31, 0, 1, 1);
		send(8'h32, 1, 1, 1);
		send(8'h33, 0, 1, 1);
		chk("masked irq", 32'h0, {31'h0, irq});
		rc(A_IST, 32'h01, "irq status before head");
		rc(A_LSR, 32'h01, "clean head");
		rc(A_RXH, 32'h31, "fifo data 1");
		rc(A_IST, 32'h03, "irq status at head");
		wr(A_MSK, 32'h02);
		chk("irq raised", 32'h1, {31'h0, irq});
		rc(A_LSR, 32'h05, "parity head");
		rc(A_RXH, 32'h32, "fifo data 2");
		rc(A_LSR, 32'h01, "next head");
		rc(A_RXH, 32'h33, "fifo data 3");
		rc(A_LSR, 32'h00, "fifo empty");
		wr(A_IST, 32'h03);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("fifo head test done");
		setlcr(8'h03);
		send(8'h55, 0, 2, 0);
		send(8'hC3, 0, 1, 1);
		rc(A_LSR, 32'h09, "framing head");
		rc(A_RXH, 32'h55, "bad stop data");
		rc(A_LSR, 32'h01, "resync head");
		rc(A_RXH, 32'hC3, "resync data");
		setlcr(8'h07);
		send(8'hA1, 0, 1, 0);
		send(8'hA2, 0, 1, 1);
		rc(A_RXH, 32'hA1, "two stop data 1");
		rc(A_RXH, 32'hA2, "two stop data 2");
		rc(A_LSR, 32'h00, "no framing");
		$display("framing test done");
		setlcr(8'h03);
		tx.hold_low(12);
		rc(A_LSR, 32'h19, "break");
		rc(A_RXH, 32'h00, "break char");
		rc(A_LSR, 32'h00, "single break char");
		// Twelve-bit frame: eleven low bits is short of a break
		setlcr(8'h1F);
		tx.hold_low(11);
		rc(A_LSR, 32'h09, "short low");
		rc(A_RXH, 32'h00, "short low char");
		$display("break test done");
		setlcr(8'h03);
		for (int i = 0; i < 17; i++) send(8'h40 + i[7:0], 0, 1, 1);
		rc(A_LSR, 32'h03, "fifo overrun");
		for (int i = 0; i < 16; i++) rc(A_RXH, 32'h40 + i, "fifo drain");
		rc(A_LSR, 32'h00, "drained");
		send(8'h77, 0, 1, 1);
		rc(A_LSR, 32'h01, "before flush");
		wr(A_FCR, 32'h03);
		rc(A_LSR, 32'h00, "flushed");
		$display("fifo fill test done");
		rd(8'h3C);
		chk("unmapped resp", `ULF_RESP_SLVERR, resp);
		wr(8'h3C, 32'h0);
		chk("unmapped write resp", `ULF_RESP_SLVERR, resp);
		wr(A_DIV, 32'h103);
		chk("write resp", `ULF_RESP_OKAY, resp);
		rc(A_DIV, 32'h103, "divisor");
		chk("read resp", `ULF_RESP_OKAY, resp);
		wr(A_MSK, 32'h3);
		srst <= 1'b1;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("irq after reset", 32'h0, {31'h0, irq});
		rc(A_LCR, 32'h0, "line ctrl reset");
		rc(A_FCR, 32'h0, "fifo ctrl reset");
		rc(A_DIV, 32'h1, "divisor reset");
		rc(A_MSK, 32'h0, "mask reset");
		rc(A_LSR, 32'h0, "line state reset");
		$display("register test done");
		give_verdict();
	end
endmodule
`default_nettype wire
